// ---- dspp_ctrl_model.sv ----
// Behavioural controller driving the three-wire programming pins
`default_nettype none
module dspp_ctrl_model;
  timeunit 1ns;
  timeprecision 100ps;
  logic sclk = 1'b0;
  logic sdata = 1'b0;
  logic load_strobe = 1'b0;
  logic en_n = 1'b0;
  // One 11-bit word; strobe low shifts without loading
  task automatic send(input logic [10:0] w, input logic mask, input logic strobe);
    en_n <= mask;
    #24;
    for (int i = 0; i < 11; i++) begin
      sdata <= w[i];
      #24 sclk <= 1'b1;
      #24 sclk <= 1'b0;
    end
    // No pull on the data line, so never leave a stale bit showing
    sdata <= ~w[10];
    #24 load_strobe <= strobe;
    // Shift clock held still while the strobe is high
    #40 load_strobe <= 1'b0;
    #24 en_n <= 1'b0;
  endtask : send
endmodule : dspp_ctrl_model
`default_nettype wire

// ---- dspp_pkg.sv ----
// Types shared by the serial delay programming port
`default_nettype none
package dspp_pkg;

  // Pin inputs as they pass the synchroniser
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic load_strobe;
    logic en_n;
    logic in0;
    logic in1;
  } dspp_pins_t;

  // Settings held after a load
  typedef struct packed {
    logic cascade;
    logic [8:0] code_a;
    logic [8:0] code_b;
  } dspp_setting_t;

  // One differential output pair
  typedef struct packed {
    logic q;
    logic q_n;
  } dspp_pair_t;

endpackage : dspp_pkg
`default_nettype wire

// ---- dspp_port.sv ----
// Serial delay programming port: pin sampling, shift word, load latch, channel steering, AXI regs
//
// Operation
// - 11-bit shift register, one bit per rising clock
// - Load rise opens latch, transparent while high
// - Load fall freezes the latched word
// - Frozen latch ignores serial activity until reload
// - Captured select bits steer channel and path
// - Enable high forces true low, complement high
// - Loads succeed whether or not masking used
// - Channel delay is code times 11 ps
// - Cascade total delay is sum of channels
// - Reported delays exclude fixed intrinsic delay
// - Order: select, mode, code LSB first
// - Cascade routes input 0 to output 1
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`include "dspp_regs.svh"
`default_nettype none

module dspp_port (
  input wire logic MCLK_I,
  input wire logic NRST_I,
  input wire logic SCLK_I,
  input wire logic SDATA_I,
  input wire logic LOAD_STROBE_I,
  input wire logic EN_N_I,
  input wire logic IN0_I,
  input wire logic IN1_I,
  output logic Q0_O,
  output logic Q0_N_O,
  output logic Q1_O,
  output logic Q1_N_O,
  output logic CASCADE_O,
  output logic [8:0] CODE_A_O,
  output logic [8:0] CODE_B_O,
  output logic [12:0] DELAY_A_PS_O,
  output logic [12:0] DELAY_B_PS_O,
  output logic [13:0] DELAY_TOTAL_PS_O,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  default clocking dspp_cb @(posedge MCLK_I);
  endclocking
  default disable iff (!NRST_I);

  // Pin synchroniser; stage one feeds stage two only
  dspp_pkg::dspp_pins_t pins_meta;
  dspp_pkg::dspp_pins_t pins;
  logic sclk_prev;
  logic sclk_rise;

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pins_meta <= '0;
      pins <= '0;
      sclk_prev <= 1'b0;
    end else begin
      pins_meta <= {SCLK_I, SDATA_I, LOAD_STROBE_I, EN_N_I, IN0_I, IN1_I};
      pins <= pins_meta;
      sclk_prev <= pins.sclk;
    end
  end

  assign sclk_rise = pins.sclk && !sclk_prev;

  // Shift word and settings
  logic [10:0] shift_word;
  logic [10:0] next_shift_word;
  dspp_pkg::dspp_setting_t setting;
  dspp_pkg::dspp_setting_t next_setting;

  always_comb begin
    next_shift_word = shift_word;
    next_setting = setting;
    if (sclk_rise) begin
      // First bit in walks down to bit 0 after eleven edges
      next_shift_word = {pins.sdata, shift_word[10:1]};
    end
    // Transparent while load is high; the enable is not consulted
    if (pins.load_strobe) begin
      next_setting.cascade = shift_word[`DSPP_MODE_POS];
      if (!shift_word[`DSPP_PSEL_POS]) begin
        next_setting.code_a = shift_word[`DSPP_CODE_MSB:`DSPP_CODE_LSB];
      end else begin
        next_setting.code_b = shift_word[`DSPP_CODE_MSB:`DSPP_CODE_LSB];
      end
    end
    // Load low: setting holds whatever the shift word does
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      shift_word <= '0;
      setting <= '0;
    end else begin
      shift_word <= next_shift_word;
      setting <= next_setting;
    end
  end

  // Software mask, same effect as the enable pin
  logic sw_mask;
  logic masked;
  assign masked = pins.en_n || sw_mask;

  // Output steering and delay figures
  dspp_pkg::dspp_pair_t pair0;
  dspp_pkg::dspp_pair_t pair1;
  dspp_pkg::dspp_pair_t next_pair0;
  dspp_pkg::dspp_pair_t next_pair1;
  logic [12:0] ps_a;
  logic [12:0] ps_b;
  logic [13:0] ps_total;
  logic [12:0] next_ps_a;
  logic [12:0] next_ps_b;
  logic [13:0] next_ps_total;

  always_comb begin
    next_pair0 = '{q: pins.in0, q_n: !pins.in0};
    next_pair1 = setting.cascade ? '{q: pins.in0, q_n: !pins.in0}
                                 : '{q: pins.in1, q_n: !pins.in1};
    if (setting.cascade) begin
      next_pair0 = '{q: 1'b0, q_n: 1'b1};
    end
    if (masked) begin
      next_pair0 = '{q: 1'b0, q_n: 1'b1};
      next_pair1 = '{q: 1'b0, q_n: 1'b1};
    end
    // Figures leave out the fixed path delay, which is analog
    next_ps_a = 13'(setting.code_a) * `DSPP_STEP_PS;
    next_ps_b = 13'(setting.code_b) * `DSPP_STEP_PS;
    next_ps_total = setting.cascade ? 14'(next_ps_a) + 14'(next_ps_b)
                                    : 14'(next_ps_a);
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pair0 <= '{q: 1'b0, q_n: 1'b1};
      pair1 <= '{q: 1'b0, q_n: 1'b1};
      ps_a <= '0;
      ps_b <= '0;
      ps_total <= '0;
    end else begin
      pair0 <= next_pair0;
      pair1 <= next_pair1;
      ps_a <= next_ps_a;
      ps_b <= next_ps_b;
      ps_total <= next_ps_total;
    end
  end

  assign Q0_O = pair0.q;
  assign Q0_N_O = pair0.q_n;
  assign Q1_O = pair1.q;
  assign Q1_N_O = pair1.q_n;
  assign CASCADE_O = setting.cascade;
  assign CODE_A_O = setting.code_a;
  assign CODE_B_O = setting.code_b;
  assign DELAY_A_PS_O = ps_a;
  assign DELAY_B_PS_O = ps_b;
  assign DELAY_TOTAL_PS_O = ps_total;

  // AXI4-Lite slave: one write and one read in flight
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic b_valid;
  logic [1:0] b_resp;
  logic r_valid;
  logic [1:0] r_resp;
  logic [31:0] r_data;
  logic next_aw_held;
  logic next_w_held;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_b_valid;
  logic [1:0] next_b_resp;
  logic next_r_valid;
  logic [1:0] next_r_resp;
  logic [31:0] next_r_data;
  logic next_sw_mask;
  logic [31:0] rd_mux;
  logic rd_hit;

  assign S_AXI_AWREADY = !aw_held && !b_valid;
  assign S_AXI_WREADY = !w_held && !b_valid;
  assign S_AXI_ARREADY = !r_valid;

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (S_AXI_ARADDR)
      `DSPP_OFS_CTRL: rd_mux[`DSPP_CTRL_MASK_POS] = sw_mask;
      `DSPP_OFS_STATUS: begin
        rd_mux[`DSPP_STAT_CASCADE_POS] = setting.cascade;
        rd_mux[`DSPP_STAT_OPEN_POS] = pins.load_strobe;
        rd_mux[`DSPP_STAT_EN_N_POS] = pins.en_n;
        rd_mux[`DSPP_STAT_MASKED_POS] = masked;
      end
      `DSPP_OFS_CODE_A: rd_mux[8:0] = setting.code_a;
      `DSPP_OFS_CODE_B: rd_mux[8:0] = setting.code_b;
      `DSPP_OFS_SHIFT: rd_mux[10:0] = shift_word;
      `DSPP_OFS_DELAY: rd_mux[13:0] = ps_total;
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_b_valid = b_valid;
    next_b_resp = b_resp;
    next_sw_mask = sw_mask;
    next_r_valid = r_valid;
    next_r_resp = r_resp;
    next_r_data = r_data;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_w_held = 1'b1;
      next_w_data = S_AXI_WDATA;
      next_w_strb = S_AXI_WSTRB;
    end
    if (aw_held && w_held) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_b_valid = 1'b1;
      if (aw_addr == `DSPP_OFS_CTRL) begin
        next_b_resp = `DSPP_RESP_OKAY;
        if (w_strb[0]) begin
          next_sw_mask = w_data[`DSPP_CTRL_MASK_POS];
        end
      end else begin
        // Read-only and unmapped words refuse writes
        next_b_resp = `DSPP_RESP_SLVERR;
      end
    end
    if (b_valid && S_AXI_BREADY) begin
      next_b_valid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_r_valid = 1'b1;
      next_r_data = rd_mux;
      next_r_resp = rd_hit ? `DSPP_RESP_OKAY : `DSPP_RESP_SLVERR;
    end else if (r_valid && S_AXI_RREADY) begin
      next_r_valid = 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      b_valid <= 1'b0;
      b_resp <= `DSPP_RESP_OKAY;
      sw_mask <= 1'(`DSPP_CTRL_RESET);
      r_valid <= 1'b0;
      r_resp <= `DSPP_RESP_OKAY;
      r_data <= '0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      b_valid <= next_b_valid;
      b_resp <= next_b_resp;
      sw_mask <= next_sw_mask;
      r_valid <= next_r_valid;
      r_resp <= next_r_resp;
      r_data <= next_r_data;
    end
  end

  assign S_AXI_BVALID = b_valid;
  assign S_AXI_BRESP = b_resp;
  assign S_AXI_RVALID = r_valid;
  assign S_AXI_RRESP = r_resp;
  assign S_AXI_RDATA = r_data;

  // Checks
  sequence s_load_rise;
    !pins.load_strobe ##1 pins.load_strobe;
  endsequence

  sequence s_load_fall;
    pins.load_strobe ##1 !pins.load_strobe;
  endsequence

  a_shift_step: assert property (sclk_rise |=>
    shift_word == {$past(pins.sdata), $past(shift_word[10:1])})
    else $error("shift word did not advance by one bit");

  a_latch_open: assert property (s_load_rise |=>
    setting.cascade == $past(shift_word[1]))
    else $error("load rise did not pass the mode bit");

  a_latch_frozen: assert property (s_load_fall ##1 (!pins.load_strobe [*3]) |->
    $stable(setting))
    else $error("latched settings moved after load fall");

  a_idle_ignores: assert property ((!pins.load_strobe && sclk_rise) |=>
    $stable(setting))
    else $error("serial activity altered frozen settings");

  a_chan_a_load: assert property ((pins.load_strobe && !shift_word[0]) |=>
    setting.code_a == $past(shift_word[10:2]) && $stable(setting.code_b))
    else $error("select 0 load did not reach only channel A");

  a_chan_b_load: assert property ((pins.load_strobe && shift_word[0]) |=>
    setting.code_b == $past(shift_word[10:2]) && $stable(setting.code_a))
    else $error("select 1 load did not reach only channel B");

  a_mask_force: assert property (masked |=>
    !Q0_O && Q0_N_O && !Q1_O && Q1_N_O)
    else $error("masked outputs not forced");

  a_cascade_path: assert property ((setting.cascade && !masked) |=>
    !Q0_O && Q0_N_O && Q1_O == $past(pins.in0))
    else $error("cascade path not steered from input 0");

  a_step_size: assert property (##1
    DELAY_A_PS_O == 13'($past(setting.code_a)) * `DSPP_STEP_PS)
    else $error("channel A delay figure wrong");

  a_cascade_sum: assert property ($past(setting.cascade) |->
    DELAY_TOTAL_PS_O == 14'(ps_a) + 14'(ps_b))
    else $error("cascade total not the sum of channels");

  a_write_resp: assert property ((aw_held && w_held) |=> b_valid)
    else $error("write response missing");

endmodule : dspp_port
`default_nettype wire

// ---- dspp_port_tb.sv ----
// Self-checking bench for the serial delay programming port
`include "dspp_regs.svh"
`default_nettype none
module dspp_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic sel; logic casc; logic [8:0] code; int a; int b; int tot;} dspp_row_t;
  dspp_row_t rows[5] = '{'{1'b0, 1'b0, 9'h001, 1, 0, 11}, '{1'b1, 1'b0, 9'h1FF, 1, 511, 11},
    '{1'b0, 1'b1, 9'h1FF, 511, 511, 11242}, '{1'b1, 1'b1, 9'h002, 511, 2, 5643},
    '{1'b0, 1'b0, 9'h000, 0, 2, 0}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic in0 = 1'b0;
  logic in1 = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bready = 1'b0;
  logic arv = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, q0, q0n, q1, q1n, casc;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [8:0] codea, codeb;
  logic [12:0] da, db;
  logic [13:0] dt;
  int miscompares = 0;
  int n_tests = 0;
  dspp_ctrl_model ctrl();
  always #2.5 clk = ~clk;
  dspp_port DUT (.MCLK_I(clk), .NRST_I(nrst), .SCLK_I(ctrl.sclk), .SDATA_I(ctrl.sdata),
    .LOAD_STROBE_I(ctrl.load_strobe), .EN_N_I(ctrl.en_n), .IN0_I(in0), .IN1_I(in1), .Q0_O(q0),
    .Q0_N_O(q0n), .Q1_O(q1), .Q1_N_O(q1n), .CASCADE_O(casc), .CODE_A_O(codea),
    .CODE_B_O(codeb), .DELAY_A_PS_O(da), .DELAY_B_PS_O(db), .DELAY_TOTAL_PS_O(dt),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah;
    logic wh;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ah = awv & awready;
      wh = wv & wready;
      @(posedge clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end while ((awv & ~ah) | (wv & ~wh));
    do begin
      @(negedge clk);
      ah = bvalid;
      r = bresp;
      @(posedge clk);
    end while (ah !== 1'b1);
    bready <= 1'b0;
    chk(r === er, "write response");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic h;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      h = arready;
      @(posedge clk);
    end while (h !== 1'b1);
    arv <= 1'b0;
    do begin
      @(negedge clk);
      h = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end while (h !== 1'b1);
    rready <= 1'b0;
    chk(d === ed && r === er, "read data or response");
  endtask : rd

  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(codea === 9'h000 && q0n === 1'b1 && bvalid === 1'b0, "reset state");
    $display("test reset done");
    foreach (rows[i]) begin
      in0 <= 1'b1;
      in1 <= i[0];
      ctrl.send({rows[i].code, rows[i].casc, rows[i].sel}, 1'b0, 1'b1);
      repeat (8) @(posedge clk);
      chk(codea === 9'(rows[i].a) && codeb === 9'(rows[i].b), "codes");
      chk(casc === rows[i].casc && da === 13'(rows[i].a * 11), "mode or delay");
      chk(db === 13'(rows[i].b * 11) && dt === 14'(rows[i].tot), "delays");
      chk(q0 === ~rows[i].casc && q0n === rows[i].casc, "q0 route");
      chk(q1 === (rows[i].casc | i[0]) && q1n === ~q1, "q1 route");
      $display("test row %0d done", i);
    end
    // Shifting without a strobe must leave the frozen settings alone
    ctrl.send(11'h7FC, 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    chk(codea === 9'h000 && codeb === 9'h002, "latch moved");
    $display("test frozen latch done");
    ctrl.en_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk(q0 === 1'b0 && q0n === 1'b1 && q1 === 1'b0 && q1n === 1'b1, "pin mask");
    ctrl.send({9'h0AA, 1'b0, 1'b0}, 1'b1, 1'b1);
    repeat (8) @(posedge clk);
    chk(codea === 9'h0AA && q0 === 1'b1, "masked load");
    $display("test masked load done");
    rd(`DSPP_OFS_CODE_A, 32'h0000_00AA, `DSPP_RESP_OKAY);
    rd(`DSPP_OFS_DELAY, 32'h0000_074E, `DSPP_RESP_OKAY);
    rd(`DSPP_OFS_SHIFT, 32'h0000_02A8, `DSPP_RESP_OKAY);
    rd(8'h18, 32'h0, `DSPP_RESP_SLVERR);
    wr(`DSPP_OFS_STATUS, 32'h1, `DSPP_RESP_SLVERR);
    wr(`DSPP_OFS_CTRL, 32'h1, `DSPP_RESP_OKAY);
    repeat (6) @(posedge clk);
    chk(q0 === 1'b0 && q0n === 1'b1, "register mask");
    rd(`DSPP_OFS_CTRL, 32'h1, `DSPP_RESP_OKAY);
    rd(`DSPP_OFS_STATUS, 32'h0000_0008, `DSPP_RESP_OKAY);
    wr(`DSPP_OFS_CTRL, 32'h0, `DSPP_RESP_OKAY);
    $display("test registers done");
    nrst <= 1'b0;
    @(posedge clk);
    chk(codea === 9'h000 && casc === 1'b0 && q0n === 1'b1, "mid-run reset");
    nrst <= 1'b1;
    rd(`DSPP_OFS_SHIFT, 32'h0, `DSPP_RESP_OKAY);
    $display("test second reset done");
    print_verdict();
  end

  // Whole run needs about 5 us
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule : dspp_port_tb
`default_nettype wire

// ---- dspp_regs.svh ----
// Register offsets, field positions, reset values and timing figures of the serial delay port
`ifndef DSPP_REGS_SVH
`define DSPP_REGS_SVH

`define DSPP_WORD_W 11
`define DSPP_CODE_W 9
`define DSPP_PSEL_POS 0
`define DSPP_MODE_POS 1
`define DSPP_CODE_LSB 2
`define DSPP_CODE_MSB 10
`define DSPP_PS_W 13
`define DSPP_TOTAL_W 14
`define DSPP_STEP_PS 13'h000B
`define DSPP_MAX_CODE_PS 13'h15F5
`define DSPP_MCLK_PERIOD_PS 5000
`define DSPP_LINK_PERIOD_PS 48000
`define DSPP_LINK_CYCLES (`DSPP_LINK_PERIOD_PS / `DSPP_MCLK_PERIOD_PS)

`define DSPP_ADDR_W 8
`define DSPP_OFS_CTRL 8'h00
`define DSPP_OFS_STATUS 8'h04
`define DSPP_OFS_CODE_A 8'h08
`define DSPP_OFS_CODE_B 8'h0C
`define DSPP_OFS_SHIFT 8'h10
`define DSPP_OFS_DELAY 8'h14
`define DSPP_CTRL_MASK_POS 0
`define DSPP_CTRL_RESET 32'h0000_0000
`define DSPP_STAT_CASCADE_POS 0
`define DSPP_STAT_OPEN_POS 1
`define DSPP_STAT_EN_N_POS 2
`define DSPP_STAT_MASKED_POS 3
`define DSPP_RESP_OKAY 2'h0
`define DSPP_RESP_SLVERR 2'h2

`endif
